// [pidc_core.sv]
// Notes on behaviour
// - each bank is 16 data plus 2 parity
// - one bank or one pair is minimum
// - same row hits use column strobes only
// - rows close after ten microseconds, then precharge
// - banks switch at 1 Kbyte page boundaries
// - interleave at page, not word, granularity
// - hit space grows with ways and density; page fixed at 1 Kbyte here, so ways only
// - gate register bit 1 drives a20 gate
// - drive row, column, write and rom strobes
// - ready after programmed wait states
// - row strobe per bank, column per byte
// - buffer enable on internal register io
// - data latch enable and direction control
// - local memory flag during local accesses
// - refresh row goes onto memory address
// - staggered refresh, banks 0/3 then 1/2
//
// top of the memory controller: dram and rom cycles, refresh, system control
// assumes the bus controller holds request inputs stable until ready
`timescale 1ns/10ps
module pidc_core #(
    parameter int ROW_TIMEOUT = pidc_pkg::ROW_TIMEOUT_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic rom_sel,
    input wire logic [23:0] proc_addr,
    input wire logic byte_high_n,
    input wire logic byte_low_n,
    input wire logic [1:0] interleave_mode,
    input wire logic [3:0] hit_wait,
    input wire logic [3:0] miss_wait,
    input wire logic reg_io_access,
    input wire logic gate_reg_write,
    input wire logic [7:0] gate_reg_data,
    input wire logic refresh_n,
    input wire logic [9:0] refresh_row,
    output logic [3:0] row_strobe_n,
    output logic [7:0] col_strobe_n,
    output logic memory_write_enable_n,
    output logic rom_chip_select_n,
    output logic [9:0] memory_address,
    output logic ready,
    output logic register_buffer_enable,
    output logic data_latch_enable,
    output logic data_direction,
    output logic local_memory_flag,
    output logic a20_line_gate
);
    // ========================================
    // address decoding
    // bank select takes address bits just above the page, so a whole
    // 1 Kbyte page stays in one bank
    // single mode keeps every access in bank 0, one bank is enough
    function automatic logic [1:0] bank_of(input logic [23:0] a, input logic [1:0] m);
        logic [1:0] b;
        b = 2'h0;
        unique case (m)
            2'h1: b = {1'b0, a[pidc_pkg::PAGE_SHIFT]};
            2'h2: b = a[pidc_pkg::PAGE_SHIFT+1:pidc_pkg::PAGE_SHIFT];
            default: b = 2'h0;
        endcase
        return b;
    endfunction

    // row lies above the bank bits so the column covers a whole page
    function automatic logic [9:0] row_of(input logic [23:0] a, input logic [1:0] m);
        logic [9:0] r;
        r = 10'h000;
        unique case (m)
            2'h1: r = a[pidc_pkg::PAGE_SHIFT+10:pidc_pkg::PAGE_SHIFT+1];
            2'h2: r = a[pidc_pkg::PAGE_SHIFT+11:pidc_pkg::PAGE_SHIFT+2];
            default: r = a[pidc_pkg::PAGE_SHIFT+9:pidc_pkg::PAGE_SHIFT];
        endcase
        return r;
    endfunction

    logic [1:0] req_bank;
    logic [9:0] req_row;
    logic [9:0] col_addr;
    // word column within the 1 Kbyte page
    assign req_bank = bank_of(proc_addr, interleave_mode);
    assign req_row = row_of(proc_addr, interleave_mode);
    assign col_addr = {1'b0, proc_addr[9:1]};

    // ========================================
    // state
    pidc_pkg::pidc_state_t state_q, state_d;
    logic [3:0] open_q, open_d;
    logic [3:0] ras_n_q, ras_n_d;
    logic [7:0] cas_n_q, cas_n_d;
    logic we_n_q, we_n_d;
    logic rom_n_q, rom_n_d;
    logic [9:0] ma_q, ma_d;
    logic [3:0] wait_q, wait_d;
    logic rdy_q, rdy_d;
    logic dle_q, dle_d;
    logic dir_q, dir_d;
    logic lmf_q, lmf_d;
    logic a20_q, a20_d;
    logic [15:0] tmo_q [4];
    logic [15:0] tmo_d [4];
    logic [3:0] tmo_hit;
    logic tbl_wr;
    logic [9:0] open_row;
    logic [1:0] rd_bank_q, rd_bank_d;

    // open row per bank; a miss re-opens with the new row
    // one live 1 Kbyte page per bank, so hit space is ways times page;
    // larger dram pages are not modelled
    pidc_row_table #(
        .ENTRIES(pidc_pkg::NUM_BANKS),
        .WIDTH(pidc_pkg::ROW_BITS)
    ) u_rows (
        .mclk(mclk),
        .rst(rst),
        .wr_en(tbl_wr),
        .wr_index(req_bank),
        .wr_row(req_row),
        .rd_index(req_bank),
        .rd_row(open_row)
    );

    // row active timers, one per bank
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            tmo_hit[i] = open_q[i] && (tmo_q[i] == 16'(ROW_TIMEOUT - 1));
            if (!open_q[i] || (state_q == pidc_pkg::PIDC_ROW && req_bank == 2'(i))) begin
                tmo_d[i] = 16'h0000;
            end else if (tmo_hit[i]) begin
                // hold at the limit so a timeout during a busy cycle is not lost
                tmo_d[i] = tmo_q[i];
            end else begin
                tmo_d[i] = tmo_q[i] + 16'h0001;
            end
        end
    end

    // main sequencer; row table read is one cycle late, so it is
    // consulted from the idle cycle after the address is seen
    always_comb begin
        state_d = state_q;
        open_d = open_q;
        ras_n_d = ras_n_q;
        cas_n_d = 8'hFF;
        we_n_d = 1'b1;
        rom_n_d = 1'b1;
        ma_d = ma_q;
        wait_d = wait_q;
        rdy_d = 1'b0;
        dle_d = 1'b0;
        dir_d = dir_q;
        lmf_d = 1'b0;
        tbl_wr = 1'b0;
        // bank whose open row the table read register holds next cycle
        rd_bank_d = req_bank;
        a20_d = a20_q;
        // fast gate: one write replaces the keyboard controller path
        if (gate_reg_write) begin
            a20_d = gate_reg_data[pidc_pkg::A20_GATE_BIT];
        end
        // timed out rows close, which is their precharge start
        for (int i = 0; i < 4; i++) begin
            if (tmo_hit[i] && state_q == pidc_pkg::PIDC_IDLE) begin
                open_d[i] = 1'b0;
                ras_n_d[i] = 1'b1;
            end
        end
        unique case (state_q)
            pidc_pkg::PIDC_IDLE: begin
                if (!refresh_n) begin
                    // all rows precharge before refresh
                    ras_n_d = 4'hF;
                    open_d = 4'h0;
                    wait_d = 4'(pidc_pkg::PRECHARGE_CYC);
                    state_d = pidc_pkg::PIDC_REF_PRE;
                end else if (mem_req && rom_sel) begin
                    rom_n_d = 1'b0;
                    lmf_d = 1'b1;
                    dir_d = 1'b0;
                    wait_d = hit_wait;
                    state_d = pidc_pkg::PIDC_COL;
                end else if (mem_req && !tmo_hit[req_bank] && rd_bank_q == req_bank) begin
                    lmf_d = 1'b1;
                    dir_d = mem_write;
                    if (open_q[req_bank] && open_row == req_row) begin
                        // page hit: column strobes only
                        ma_d = col_addr;
                        wait_d = hit_wait;
                        state_d = pidc_pkg::PIDC_COL;
                    end else begin
                        ras_n_d[req_bank] = 1'b1;
                        wait_d = 4'(pidc_pkg::PRECHARGE_CYC);
                        state_d = pidc_pkg::PIDC_PRECH;
                    end
                end
            end
            pidc_pkg::PIDC_PRECH: begin
                lmf_d = 1'b1;
                wait_d = wait_q - 4'h1;
                if (wait_q <= 4'h1) begin
                    ma_d = req_row;
                    ras_n_d[req_bank] = 1'b0;
                    open_d[req_bank] = 1'b1;
                    tbl_wr = 1'b1;
                    state_d = pidc_pkg::PIDC_ROW;
                end
            end
            pidc_pkg::PIDC_ROW: begin
                lmf_d = 1'b1;
                ma_d = col_addr;
                wait_d = miss_wait;
                state_d = pidc_pkg::PIDC_COL;
            end
            pidc_pkg::PIDC_COL: begin
                lmf_d = 1'b1;
                dle_d = 1'b1;
                if (rom_sel) begin
                    rom_n_d = 1'b0;
                end else begin
                    // byte lane strobes of the addressed bank
                    cas_n_d[{req_bank, 1'b1}] = byte_high_n;
                    cas_n_d[{req_bank, 1'b0}] = byte_low_n;
                    we_n_d = !mem_write;
                end
                wait_d = wait_q - 4'h1;
                if (wait_q == 4'h0) begin
                    rdy_d = 1'b1;
                    state_d = pidc_pkg::PIDC_DONE;
                end
            end
            pidc_pkg::PIDC_DONE: begin
                state_d = pidc_pkg::PIDC_IDLE;
            end
            pidc_pkg::PIDC_REF_PRE: begin
                ma_d = refresh_row;
                wait_d = wait_q - 4'h1;
                if (wait_q <= 4'h1) begin
                    ras_n_d = 4'h6; // banks 0 and 3 first
                    state_d = pidc_pkg::PIDC_REF_A;
                end
            end
            pidc_pkg::PIDC_REF_A: begin
                ras_n_d = 4'h0; // banks 1 and 2 one unit later
                state_d = pidc_pkg::PIDC_REF_B;
            end
            pidc_pkg::PIDC_REF_B: begin
                if (refresh_n) begin
                    ras_n_d = 4'hF;
                    state_d = pidc_pkg::PIDC_IDLE;
                end
            end
        endcase
    end

    // registers only
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= pidc_pkg::PIDC_IDLE;
            open_q <= 4'h0;
            ras_n_q <= 4'hF;
            cas_n_q <= 8'hFF;
            we_n_q <= 1'b1;
            rom_n_q <= 1'b1;
            ma_q <= 10'h000;
            wait_q <= 4'h0;
            rdy_q <= 1'b0;
            dle_q <= 1'b0;
            dir_q <= 1'b0;
            lmf_q <= 1'b0;
            a20_q <= 1'b0;
            rd_bank_q <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                tmo_q[i] <= 16'h0000;
            end
        end else begin
            state_q <= state_d;
            open_q <= open_d;
            ras_n_q <= ras_n_d;
            cas_n_q <= cas_n_d;
            we_n_q <= we_n_d;
            rom_n_q <= rom_n_d;
            ma_q <= ma_d;
            wait_q <= wait_d;
            rdy_q <= rdy_d;
            dle_q <= dle_d;
            dir_q <= dir_d;
            lmf_q <= lmf_d;
            a20_q <= a20_d;
            rd_bank_q <= rd_bank_d;
            tmo_q <= tmo_d;
        end
    end

    // ========================================
    // outputs
    assign row_strobe_n = ras_n_q;
    assign col_strobe_n = cas_n_q;
    assign memory_write_enable_n = we_n_q;
    assign rom_chip_select_n = rom_n_q;
    assign memory_address = ma_q;
    assign ready = rdy_q;
    assign data_latch_enable = dle_q;
    assign data_direction = dir_q;
    assign local_memory_flag = lmf_q;
    assign a20_line_gate = a20_q;
    // combinational so the external buffer opens with the io cycle
    assign register_buffer_enable = reg_io_access;
endmodule

// [pidc_pkg.sv]
// package for the page interleaved dram controller
// assumes a single 40 MHz clock domain; no software register bus
package pidc_pkg;
    // bank organisation
    localparam int NUM_BANKS = 4;
    localparam int BANK_DATA_BITS = 16;
    localparam int BANK_PARITY_BITS = 2;
    localparam int BANK_WIDTH = BANK_DATA_BITS + BANK_PARITY_BITS;
    localparam int ROW_BITS = 10;
    localparam int COL_BITS = 10;
    // interleave modes
    typedef enum logic [1:0] {
        PIDC_MODE_SINGLE = 2'h0,
        PIDC_MODE_TWO_WAY = 2'h1,
        PIDC_MODE_FOUR_WAY = 2'h2
    } pidc_mode_t;
    // page size of a 256k bank, in bytes, and its address bit position
    localparam int PAGE_BYTES = 1024;
    localparam int PAGE_SHIFT = 10;
    // fast a20 gate bit position in the gate control register
    localparam int A20_GATE_BIT = 1;
    localparam logic [7:0] GATE_REG_RESET = 8'h00;
    // row timeout and precharge
    localparam int CLK_MHZ = 40;
    localparam int ROW_TIMEOUT_US = 10;
    localparam int ROW_TIMEOUT_CYC = ROW_TIMEOUT_US * CLK_MHZ;
    localparam int PRECHARGE_NS = 100;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_STAGGER_CYC = 1;
    // default wait states
    localparam logic [3:0] HIT_WAIT_RESET = 4'h0;
    localparam logic [3:0] MISS_WAIT_RESET = 4'h2;
    // controller states, gray along the access path
    typedef enum logic [2:0] {
        PIDC_IDLE = 3'h0,
        PIDC_PRECH = 3'h1,
        PIDC_ROW = 3'h3,
        PIDC_COL = 3'h2,
        PIDC_DONE = 3'h6,
        PIDC_REF_PRE = 3'h7,
        PIDC_REF_A = 3'h5,
        PIDC_REF_B = 3'h4
    } pidc_state_t;
endpackage

// [pidc_row_table.sv]
// per bank open row memory with a registered read port
// assumes write and read in the same clock domain
`timescale 1ns/10ps
module pidc_row_table #(
    parameter int ENTRIES = 4,
    parameter int WIDTH = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [$clog2(ENTRIES)-1:0] wr_index,
    input wire logic [WIDTH-1:0] wr_row,
    input wire logic [$clog2(ENTRIES)-1:0] rd_index,
    output logic [WIDTH-1:0] rd_row
);
    // ========================================
    // storage
    logic [WIDTH-1:0] mem_q [ENTRIES];
    logic [WIDTH-1:0] rd_q;

    // write and registered read; reset clears only the read register
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem_q[wr_index] <= wr_row;
        end
        if (rst) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[rd_index];
        end
    end
    assign rd_row = rd_q;
endmodule

// [pidc_core_asserts.sv]
// checker for the memory controller core ports
// assumes one clock domain and a bind onto every pidc_core
`timescale 1ns/10ps
module pidc_core_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_io_access,
    input wire logic gate_reg_write,
    input wire logic [7:0] gate_reg_data,
    input wire logic refresh_n,
    input wire logic [9:0] refresh_row,
    input wire logic [3:0] row_strobe_n,
    input wire logic [7:0] col_strobe_n,
    input wire logic memory_write_enable_n,
    input wire logic rom_chip_select_n,
    input wire logic [9:0] memory_address,
    input wire logic ready,
    input wire logic register_buffer_enable,
    input wire logic data_latch_enable,
    input wire logic data_direction,
    input wire logic local_memory_flag,
    input wire logic a20_line_gate
);
    // ====
    // properties, all on the one clock
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    AST_BUF_EN: assert property (register_buffer_enable == reg_io_access)
        else $error("buffer enable differs from io access");
    AST_A20_LOAD: assert property (gate_reg_write |=> a20_line_gate == $past(gate_reg_data[1]))
        else $error("gate did not take bit 1");
    AST_A20_HOLD: assert property (!gate_reg_write |=> $stable(a20_line_gate))
        else $error("gate moved without a write");
    AST_RDY_PULSE: assert property (ready |=> !ready)
        else $error("ready longer than one cycle");
    AST_RDY_FLAG: assert property (ready |-> $past(local_memory_flag))
        else $error("ready without local flag");
    AST_DLE_COL: assert property (col_strobe_n != 8'hFF |-> data_latch_enable)
        else $error("column strobe without latch enable");
    AST_WE_DIR: assert property (!memory_write_enable_n |-> data_direction)
        else $error("write strobe with read direction");
    AST_ROM_NOCAS: assert property (!rom_chip_select_n |-> col_strobe_n == 8'hFF)
        else $error("column strobe in rom cycle");
    // staggered start: only after all rows were high for the precharge
    AST_REF_STAGGER: assert property ((!refresh_n && $past(row_strobe_n) == 4'hF
        && row_strobe_n == 4'h6) |-> $past(row_strobe_n, 3) == 4'hF
        && memory_address == refresh_row ##1 row_strobe_n == 4'h0)
        else $error("refresh stagger or address wrong");
endmodule
bind pidc_core pidc_core_asserts i_pidc_core_asserts (.mclk, .rst, .reg_io_access,
    .gate_reg_write, .gate_reg_data, .refresh_n, .refresh_row, .row_strobe_n, .col_strobe_n,
    .memory_write_enable_n, .rom_chip_select_n, .memory_address, .ready,
    .register_buffer_enable, .data_latch_enable, .data_direction, .local_memory_flag,
    .a20_line_gate);

// [pidc_bus_model.sv]
// bus controller model facing the memory controller
// assumes the testbench calls its tasks; changes land on falling edges
`timescale 1ns/10ps
module pidc_bus_model (
    input wire logic mclk,
    input wire logic ready,
    input wire logic [7:0] col_strobe_n,
    input wire logic memory_write_enable_n,
    input wire logic rom_chip_select_n,
    output logic mem_req,
    output logic mem_write,
    output logic rom_sel,
    output logic [23:0] proc_addr,
    output logic byte_high_n,
    output logic byte_low_n,
    output logic refresh_n,
    output logic [9:0] refresh_row
);
    // one dram type in every bank, so any pairing is legal
    parameter int PAGE_BYTES = 1024;
    // idle bus at power up
    initial begin
        {mem_req, mem_write, rom_sel, proc_addr} = 27'h0;
        {byte_high_n, byte_low_n, refresh_n, refresh_row} = 13'h1FFF;
    end
    // request held until ready; released address shows its inverse
    task automatic access(input logic [23:0] a, input logic wr, rom, hi_n, lo_n,
        output int lat, output logic [7:0] cas, output logic we, rs);
        @(negedge mclk);
        {proc_addr, mem_write, rom_sel, byte_high_n, byte_low_n} = {a, wr, rom, hi_n, lo_n};
        // address stands one idle cycle ahead for the open row lookup
        @(negedge mclk);
        mem_req = 1'b1;
        {lat, cas, we, rs} = '0;
        while (ready !== 1'b1 && lat < 200) begin
            @(negedge mclk);
            lat++;
            cas |= ~col_strobe_n;
            we |= ~memory_write_enable_n;
            rs |= ~rom_chip_select_n;
        end
        mem_req = 1'b0;
        proc_addr = ~proc_addr;
    endtask
    // refresh row on the address lines with the strobe low
    task automatic refresh(input logic [9:0] row, input logic on);
        @(negedge mclk);
        refresh_row = on ? row : ~refresh_row;
        refresh_n = !on;
    endtask
endmodule

// [tb_top.sv]
// self-checking bench for the memory controller core
// assumes the bus model and the bound checker sit beside it
`timescale 1ns/10ps
module tb_top;
    localparam int TMO = 80;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] interleave_mode = 2'h0;
    logic [3:0] hit_wait = 4'h0;
    logic [3:0] miss_wait = 4'h2;
    logic reg_io_access = 1'b0;
    logic gate_reg_write = 1'b0;
    logic [7:0] gate_reg_data = 8'h00;
    logic mem_req, mem_write, rom_sel, byte_high_n, byte_low_n, refresh_n;
    logic [23:0] proc_addr;
    logic [9:0] refresh_row, memory_address;
    logic [3:0] row_strobe_n;
    logic [7:0] col_strobe_n, cas;
    logic memory_write_enable_n, rom_chip_select_n, ready, register_buffer_enable;
    logic data_latch_enable, data_direction, local_memory_flag, a20_line_gate, we, rs;
    int lat, l0;
    int errors = 0;
    int total_checks = 0;
    // ====
    // clock, design and far side
    always #12.5 mclk = ~mclk;
    pidc_core #(.ROW_TIMEOUT(TMO)) i_pidc_core (.mclk, .rst, .mem_req, .mem_write, .rom_sel,
        .proc_addr, .byte_high_n, .byte_low_n, .interleave_mode, .hit_wait, .miss_wait,
        .reg_io_access, .gate_reg_write, .gate_reg_data, .refresh_n, .refresh_row,
        .row_strobe_n, .col_strobe_n, .memory_write_enable_n, .rom_chip_select_n,
        .memory_address, .ready, .register_buffer_enable, .data_latch_enable,
        .data_direction, .local_memory_flag, .a20_line_gate);
    pidc_bus_model i_pidc_bus_model (.mclk, .ready, .col_strobe_n, .memory_write_enable_n,
        .rom_chip_select_n, .mem_req, .mem_write, .rom_sel, .proc_addr, .byte_high_n,
        .byte_low_n, .refresh_n, .refresh_row);
    // ====
    // shared helpers
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic acc(input logic [23:0] a, input logic wr, rom, hi_n, lo_n);
        i_pidc_bus_model.access(a, wr, rom, hi_n, lo_n, lat, cas, we, rs);
        check("ready in time", 32'(lat < 200), 32'h1);
        check("local flag", local_memory_flag, 1'b1);
        check("latch enable", data_latch_enable, 1'b1);
        check("direction", data_direction, wr);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_sysctl;
        @(negedge mclk);
        {reg_io_access, gate_reg_write, gate_reg_data} = {2'b11, 8'h02};
        #1 check("buffer enable", register_buffer_enable, 1'b1);
        @(negedge mclk);
        check("a20 set", a20_line_gate, 1'b1);
        {reg_io_access, gate_reg_data} = {1'b0, 8'hFD};
        #1 check("buffer enable off", register_buffer_enable, 1'b0);
        @(negedge mclk);
        gate_reg_write = 1'b0;
        check("a20 clear", a20_line_gate, 1'b0);
        $display("test sysctl done");
    endtask
    // hit against miss on one bank; waits come only from the counts
    task automatic t_hit_miss;
        acc(24'h000100, 1'b0, 1'b0, 1'b0, 1'b0);
        acc(24'h000102, 1'b0, 1'b0, 1'b0, 1'b0);
        l0 = lat;
        check("read lanes", {cas, we}, 9'h006);
        acc(24'h000502, 1'b0, 1'b0, 1'b0, 1'b0);
        check("miss extra", lat - l0, pidc_pkg::PRECHARGE_CYC + 3);
        hit_wait = 4'h3;
        acc(24'h000504, 1'b0, 1'b0, 1'b0, 1'b0);
        check("hit waits", lat - l0, 3);
        hit_wait = 4'h0;
        $display("test hit miss done");
    endtask
    // bank choice at page boundaries in every mode
    task automatic t_lanes;
        logic [1:0] md[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        logic [23:0] ad[5] = '{24'h000400, 24'h0003FE, 24'h000400, 24'h000C00, 24'h000800};
        logic [2:0] ctl[5] = '{3'b011, 3'b000, 3'b101, 3'b011, 3'b000};
        logic [7:0] ec[5] = '{8'h02, 8'h03, 8'h04, 8'h80, 8'h30};
        for (int i = 0; i < 5; i++) begin
            interleave_mode = md[i];
            acc(ad[i], ctl[i][0], 1'b0, ctl[i][2], ctl[i][1]);
            check("lane strobes", cas, ec[i]);
            check("write strobe", we, ctl[i][0]);
        end
        $display("test lanes done");
    endtask
    task automatic t_rom;
        acc(24'h0F0000, 1'b0, 1'b1, 1'b0, 1'b0);
        check("rom select", {rs, cas}, 9'h100);
        $display("test rom done");
    endtask
    // every bank keeps its own page live: two and four pages of hits
    task automatic t_hit_space;
        logic [23:0] ad[12] = '{24'h000000, 24'h000400, 24'h0003FE, 24'h0007FE,
            24'h000000, 24'h000400, 24'h000800, 24'h000C00,
            24'h000002, 24'h000402, 24'h000802, 24'h000C02};
        i_pidc_bus_model.refresh(10'h155, 1'b1);
        repeat (8) @(negedge mclk);
        i_pidc_bus_model.refresh(10'h000, 1'b0);
        for (int i = 0; i < 12; i++) begin
            interleave_mode = (i < 4) ? 2'h1 : 2'h2;
            acc(ad[i], 1'b0, 1'b0, 1'b0, 1'b0);
            if (i == 2 || i == 3 || i > 7) begin
                check("hit space", lat, 2);
            end
        end
        $display("test hit space done");
    endtask
    task automatic t_refresh;
        i_pidc_bus_model.refresh(10'h2A5, 1'b1);
        @(negedge mclk);
        check("refresh precharge", row_strobe_n, 4'hF);
        repeat (7) @(negedge mclk);
        check("refresh rows", {row_strobe_n, memory_address}, {4'h0, 10'h2A5});
        i_pidc_bus_model.refresh(10'h000, 1'b0);
        $display("test refresh done");
    endtask
    task automatic t_timeout;
        interleave_mode = 2'h0;
        acc(24'h000200, 1'b0, 1'b0, 1'b0, 1'b0);
        check("row kept open", row_strobe_n[0], 1'b0);
        check("only bank 0", row_strobe_n[3:1], 3'h7);
        repeat (TMO + 20) @(negedge mclk);
        check("rows timed out", row_strobe_n, 4'hF);
        $display("test timeout done");
    endtask
    // ====
    // main sequence and watchdog
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        t_sysctl;
        t_hit_miss;
        t_lanes;
        t_rom;
        t_hit_space;
        t_refresh;
        t_timeout;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        $display("unexpected watchdog: expected end seen hang");
        wrap_up;
    end
endmodule
